/* codec_reset_init_sequencer.sv */
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Reset, calibration and access-window sequencing for the codec core
module codec_reset_init_sequencer
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        chip_powerdown_n,
  input  wire logic        frame_select_clock,
  input  wire logic        mclk_tick,
  input  wire logic        ratio_384,
  input  wire logic [15:0] adc_left,
  input  wire logic [15:0] adc_right,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [15:0]      capture_data_out_0,
  output logic [15:0]      capture_data_out_1,
  output logic [15:0]      play_left,
  output logic [15:0]      play_right,
  output logic             play_drive_en,
  output logic             input_gain_stage_a_mute,
  output logic             input_gain_stage_b_mute,
  output logic             init_done,
  output logic             int_clk_tick
);
  typedef struct packed {
    codec_seq_pkg::phase_type phase;
    logic                     lr_d;
    logic [12:0]              cal_cnt;
    logic                     cal_busy;
    logic                     stat;
    logic [5:0]               block_power_bits;
    logic [31:0]              play_word;
    logic                     aw_got;
    logic                     w_got;
    logic [31:0]              awaddr;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [15:0]              cap0;
    logic [15:0]              cap1;
    logic [15:0]              pl;
    logic [15:0]              pr;
    logic                     pdrive;
    logic                     mute_a;
    logic                     mute_b;
  } seq_type;
  seq_type s_r, s_nxt;

  logic                      frame_tick;
  logic                      adc_on;
  logic                      adc_on_nxt;
  codec_seq_pkg::sample_type cap_in;
  codec_seq_pkg::sample_type cap_dly;
  codec_seq_pkg::sample_type play_in;
  codec_seq_pkg::sample_type play_dly;

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // Both capture converters off when the ADC power pair is zero
  function automatic logic adc_pair_on(input logic [5:0] pm);
    return pm[codec_seq_pkg::PWR_ADC_LO +: 2] != 2'b00;
  endfunction

  mclk_scaler u_scaler
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ratio_384 (ratio_384),
    .mclk_tick (mclk_tick),
    .int_tick  (int_clk_tick)
  );

  // Capture path: converter words delayed by the decimation latency
  assign cap_in = '{cap_valid: 1'b1, left: adc_left, right: adc_right};
  latency_line u_cap_lat
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .depth      (codec_seq_pkg::CAP_LAT), // [R18]
    .frame_tick (frame_tick),
    .din        (cap_in),
    .dout       (cap_dly)
  );

  // Playback path runs regardless of calibration state
  assign play_in = '{cap_valid: 1'b1, left: s_r.play_word[31:16],
                     right: s_r.play_word[15:0]};
  latency_line u_play_lat
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .depth      (codec_seq_pkg::PLAY_LAT), // [R19]
    .frame_tick (frame_tick),
    .din        (play_in),
    .dout       (play_dly)
  );

  // Frame clock rising edge marks one sample period
  assign frame_tick = frame_select_clock && !s_r.lr_d; // [R24]
  assign adc_on = adc_pair_on(s_r.block_power_bits);

  always_comb
  begin
    s_nxt = s_r;
    adc_on_nxt = adc_on;
    s_nxt.lr_d = frame_select_clock;

    // Pin low forces power-down and full register reset
    if (!chip_powerdown_n)
    begin
      s_nxt = '0;
      s_nxt.lr_d = frame_select_clock;
      s_nxt.phase = codec_seq_pkg::ST_PD; // [R22]
      s_nxt.block_power_bits = codec_seq_pkg::PWR_RESET; // [R8]
    end
    else
    begin
      case (s_r.phase)
        codec_seq_pkg::ST_PD:
        begin
          // Full init: every register to its initial value
          s_nxt.block_power_bits = codec_seq_pkg::PWR_RESET; // [R16]
          s_nxt.phase = codec_seq_pkg::ST_INIT1;
        end
        codec_seq_pkg::ST_INIT1:
        begin
          // Read-only status cleared, calibration armed
          s_nxt.stat = 1'b0; // [R16]
          s_nxt.cal_cnt = '0;
          s_nxt.cal_busy = 1'b1;
          s_nxt.phase = codec_seq_pkg::ST_INIT2;
        end
        codec_seq_pkg::ST_INIT2:
        begin
          // Counts sample periods from the pin release
          if (frame_tick)
            s_nxt.cal_cnt = s_r.cal_cnt + 13'h1; // [R9]
          if (frame_tick &&
              s_r.cal_cnt == codec_seq_pkg::CAL_PERIODS - 13'h1)
          begin
            s_nxt.cal_busy = 1'b0;
            s_nxt.stat = 1'b1; // [R13]
            s_nxt.phase = codec_seq_pkg::ST_RUN;
          end
        end
        codec_seq_pkg::ST_RUN:
          s_nxt.phase = codec_seq_pkg::ST_RUN;
        default:
          s_nxt.phase = codec_seq_pkg::ST_PD;
      endcase

      // AXI write: address and data taken in either order
      if (s_axi_awvalid && !s_r.aw_got)
      begin
        s_nxt.aw_got = 1'b1;
        s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.w_got)
      begin
        s_nxt.w_got = 1'b1;
        s_nxt.wdata = s_axi_wdata;
        s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
      begin
        s_nxt.aw_got = 1'b0;
        s_nxt.w_got = 1'b0;
        s_nxt.bvalid = 1'b1;
        s_nxt.bresp = codec_seq_pkg::RESP_OKAY;
        // Writes refused in ST_PD and ST_INIT1; accepted from the start of calibration (ST_INIT2)
        if (s_r.phase != codec_seq_pkg::ST_RUN &&
            s_r.phase != codec_seq_pkg::ST_INIT2)
          s_nxt.bresp = codec_seq_pkg::RESP_SLVERR; // [R17]
        else if (s_r.awaddr == codec_seq_pkg::ADDR_CTRL)
        begin
          // Power bits locked while calibration runs
          if (s_r.cal_busy)
            s_nxt.bresp = codec_seq_pkg::RESP_SLVERR; // [R12]
          else
            s_nxt.block_power_bits =
              6'(merge({26'h0, s_r.block_power_bits}, s_r.wdata,
                       s_r.wstrb));
        end
        else if (s_r.awaddr == codec_seq_pkg::ADDR_DATA_IN)
          s_nxt.play_word = merge(s_r.play_word, s_r.wdata, s_r.wstrb);
        else
          s_nxt.bresp = codec_seq_pkg::RESP_SLVERR;
      end
      if (s_r.bvalid && s_axi_bready)
        s_nxt.bvalid = 1'b0;

      // AXI read: all reads refused during the full init phase
      if (s_axi_arvalid && !s_r.rvalid)
      begin
        s_nxt.rvalid = 1'b1;
        s_nxt.rresp = codec_seq_pkg::RESP_OKAY;
        s_nxt.rdata = '0;
        if (s_r.phase != codec_seq_pkg::ST_RUN &&
            s_r.phase != codec_seq_pkg::ST_INIT2)
          s_nxt.rresp = codec_seq_pkg::RESP_SLVERR; // [R17]
        else if (s_axi_araddr == codec_seq_pkg::ADDR_CTRL)
          s_nxt.rdata = {26'h0, s_r.block_power_bits};
        else if (s_axi_araddr == codec_seq_pkg::ADDR_STATUS)
          s_nxt.rdata = {29'h0, s_r.cal_busy, adc_on, s_r.stat};
        else if (s_axi_araddr == codec_seq_pkg::ADDR_CAL_CNT)
          s_nxt.rdata = {19'h0, s_r.cal_cnt};
        else if (s_axi_araddr == codec_seq_pkg::ADDR_DATA_IN)
          s_nxt.rdata = s_r.play_word;
        else if (s_axi_araddr == codec_seq_pkg::ADDR_CAP_OUT)
          s_nxt.rdata = {s_r.cap0, s_r.cap1};
        else
          s_nxt.rresp = codec_seq_pkg::RESP_SLVERR;
      end
      else if (s_r.rvalid && s_axi_rready)
        s_nxt.rvalid = 1'b0;

      // Re-entering capture power restarts calibration
      adc_on_nxt = adc_pair_on(s_nxt.block_power_bits);
      if (s_r.phase == codec_seq_pkg::ST_RUN && !adc_on && adc_on_nxt)
      begin
        s_nxt.cal_cnt = '0;
        s_nxt.cal_busy = 1'b1; // [R23]
        s_nxt.stat = 1'b0;
        s_nxt.phase = codec_seq_pkg::ST_INIT2;
      end
    end

    // Capture forced to zero while down or calibrating
    if (s_nxt.phase != codec_seq_pkg::ST_RUN || !adc_on_nxt)
    begin
      s_nxt.cap0 = '0; // [R10] [R15]
      s_nxt.cap1 = '0;
    end
    else
    begin
      s_nxt.cap0 = cap_dly.left;
      s_nxt.cap1 = cap_dly.right;
    end

    // Playback only floats in pin power-down, not during init
    s_nxt.pdrive = (s_nxt.phase != codec_seq_pkg::ST_PD); // [R11] [R15]
    s_nxt.pl = play_dly.left;
    s_nxt.pr = play_dly.right;

    // Gain stages held muted until init completes
    s_nxt.mute_a = (s_nxt.phase != codec_seq_pkg::ST_RUN); // [R14]
    s_nxt.mute_b = (s_nxt.phase != codec_seq_pkg::ST_RUN);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
      s_r.phase <= codec_seq_pkg::ST_PD;
      s_r.block_power_bits <= codec_seq_pkg::PWR_RESET;
      s_r.mute_a <= 1'b1;
      s_r.mute_b <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Bus handshakes: each channel accepted once while unlatched
  assign s_axi_awready = !s_r.aw_got && chip_powerdown_n;
  assign s_axi_wready  = !s_r.w_got && chip_powerdown_n;
  assign s_axi_arready = !s_r.rvalid && chip_powerdown_n;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  assign capture_data_out_0      = s_r.cap0;
  assign capture_data_out_1      = s_r.cap1;
  assign play_left               = s_r.pl;
  assign play_right              = s_r.pr;
  assign play_drive_en           = s_r.pdrive;
  assign input_gain_stage_a_mute = s_r.mute_a;
  assign input_gain_stage_b_mute = s_r.mute_b;
  assign init_done               = s_r.stat;
endmodule

/* codec_reset_init_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module codec_reset_init_sequencer_tb;
  typedef struct packed
  {
    logic        wr;
    logic [31:0] a;
    logic [31:0] d;
    logic [1:0]  resp;
  } row_type;
  logic        aclk, aresetn, pd_req_n, ratio_384, fq;
  logic        chip_powerdown_n, frame_select_clock, mclk_tick;
  logic [15:0] adc_left, adc_right, play_left, play_right;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, play_drive_en, init_done;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] capture_data_out_0, capture_data_out_1;
  logic        input_gain_stage_a_mute, input_gain_stage_b_mute;
  logic        int_clk_tick;
  int          n_fail, samples_checked, f, fcnt;
  row_type     rows [4] = '{
    '{1'b0, codec_seq_pkg::ADDR_CTRL, 32'h0000_003F, 2'h0},
    '{1'b0, codec_seq_pkg::ADDR_STATUS, 32'h0000_0003, 2'h0},
    '{1'b1, codec_seq_pkg::ADDR_CTRL, 32'h0000_003F, 2'h0},
    '{1'b0, 32'h0000_0020, 32'h0000_0000, 2'h2}};
  host_clock_model u_host_clock_model (.aclk(aclk), .pd_req_n(pd_req_n),
    .chip_powerdown_n(chip_powerdown_n), .mclk_tick(mclk_tick),
    .frame_select_clock(frame_select_clock));
  codec_reset_init_sequencer u_codec_reset_init_sequencer (.*);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Frame edges since the last marked start
  always @(posedge aclk)
  begin
    if (frame_select_clock && !fq)
      fcnt++;
    fq = frame_select_clock;
  end
  // Long enough for two full calibrations
  initial
  begin
    #(80000 * 25);
    n_fail++;
    report_and_stop();
  end
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Both channels offered together; bready held until the answer
  task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Host reads carry no serial clock, so no slow-read limit applies
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic frames(input int k);
    repeat (k) @(posedge frame_select_clock);
    @(posedge aclk);
  endtask
  task automatic wait_init;
    int k;
    k = 0;
    while (init_done !== 1'b1 && k < 20000)
    begin
      @(posedge aclk);
      k++;
    end
  endtask
  // Main sequence; awkward cases follow the table
  initial
  begin
    {aresetn, pd_req_n, ratio_384, fq, s_axi_wstrb} = 8'h0F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {adc_left, adc_right} = 32'h1111_2222;
    {n_fail, samples_checked, fcnt} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("cap_pd", 16'h0000, capture_data_out_0)
    `CHK("drive_pd", 1'b0, play_drive_en)
    `CHK("done_pd", 1'b0, init_done)
    $display("test power_down done");
    pd_req_n <= 1'b1;
    fcnt = 0;
    axi_rd(codec_seq_pkg::ADDR_CTRL, rd, rr);
    `CHK("rd_early", codec_seq_pkg::RESP_SLVERR, rr)
    axi_rd(codec_seq_pkg::ADDR_CTRL, rd, rr);
    `CHK("ctrl_init", 32'h0000_003F, rd)
    axi_wr(codec_seq_pkg::ADDR_CTRL, 32'h0000_000F, rr);
    `CHK("wr_cal", codec_seq_pkg::RESP_SLVERR, rr)
    axi_wr(codec_seq_pkg::ADDR_DATA_IN, 32'h1234_ABCD, rr);
    `CHK("cap_cal", 16'h0000, capture_data_out_1)
    `CHK("mute_cal", 2'b11, {input_gain_stage_a_mute,
      input_gain_stage_b_mute})
    f = 0;
    while (play_left !== 16'h1234 && f < 40)
    begin
      frames(1);
      f++;
    end
    `CHK("play_lat", 1'b1, (f >= 15 && f <= 17))
    `CHK("play_r", 16'hABCD, play_right)
    `CHK("play_undone", 1'b0, init_done)
    `CHK("play_drv", 1'b1, play_drive_en)
    wait_init();
    `CHK("cal_len", 1'b1, (fcnt >= 4128 && fcnt <= 4130))
    $display("test calibration done");
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axi_wr(rows[i].a, rows[i].d, rr);
      else
        axi_rd(rows[i].a, rd, rr);
      `CHK("row_resp", rows[i].resp, rr)
      if (!rows[i].wr)
        `CHK("row_data", rows[i].d, rd)
    end
    $display("test register_table done");
    frames(1);
    {adc_left, adc_right} <= 32'h5A5A_A5A5;
    f = 0;
    while (capture_data_out_0 !== 16'h5A5A && f < 40)
    begin
      frames(1);
      f++;
    end
    `CHK("cap_lat", 1'b1, (f >= 17 && f <= 19))
    `CHK("cap_r", 16'hA5A5, capture_data_out_1)
    for (int r = 0; r < 2; r++)
    begin
      ratio_384 <= r[0];
      repeat (8) @(posedge aclk);
      f = 0;
      repeat (192)
      begin
        @(posedge aclk);
        f += (int_clk_tick === 1'b1);
      end
      `CHK("ticks", 1'b1, (f >= (r ? 63 : 95) && f <= (r ? 65 : 97)))
    end
    $display("test ratio done");
    axi_wr(codec_seq_pkg::ADDR_CTRL, 32'h0000_0033, rr);
    axi_wr(codec_seq_pkg::ADDR_CTRL, 32'h0000_003F, rr);
    fcnt = 0;
    repeat (3) @(posedge aclk);
    `CHK("restart", 2'b00, {init_done, |capture_data_out_0})
    axi_wr(codec_seq_pkg::ADDR_CTRL, 32'h0000_003F, rr);
    `CHK("wr_recal", codec_seq_pkg::RESP_SLVERR, rr)
    wait_init();
    `CHK("recal_len", 1'b1, (fcnt >= 4125 && fcnt <= 4130))
    $display("test restart done");
    pd_req_n <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("pd_run", 3'b000, {init_done, play_drive_en,
      |capture_data_out_1})
    $display("test pin_down done");
    report_and_stop();
  end
endmodule

/* codec_seq_checker.sv */
`timescale 1ns/1ps
// Port-level watch on power-down, calibration and bus refusals
module codec_seq_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        chip_powerdown_n,
  input wire logic        frame_select_clock,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [15:0] capture_data_out_0,
  input wire logic [15:0] capture_data_out_1,
  input wire logic        play_drive_en,
  input wire logic        input_gain_stage_a_mute,
  input wire logic        input_gain_stage_b_mute,
  input wire logic        init_done
);
  localparam int CNT_LO = 4127;
  localparam int CNT_HI = 4130;
  typedef struct packed
  {
    logic        fsc;
    logic [12:0] cnt;
    logic [31:0] awa;
  } chk_state_type;
  chk_state_type st_r;
  chk_state_type st_nxt;
  // Frames seen while init runs; restart may begin a cycle before the flag
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.fsc = frame_select_clock;
    if (!chip_powerdown_n || init_done)
      st_nxt.cnt = 13'h0000;
    else if (frame_select_clock && !st_r.fsc)
      st_nxt.cnt = st_r.cnt + 13'h0001;
    if (s_axi_awvalid && s_axi_awready)
      st_nxt.awa = s_axi_awaddr;
  end
  always_ff @(posedge aclk)
    st_r <= aresetn ? st_nxt : '0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pd_cap;
    !chip_powerdown_n |=> capture_data_out_0 == 16'h0000 && capture_data_out_1 == 16'h0000;
  endproperty
  a_pd_cap: assert property (p_pd_cap) else $error("capture live when down");
  property p_pd_float;
    !chip_powerdown_n |=> !play_drive_en;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("playback driven when down");
  property p_pd_flag;
    !chip_powerdown_n |=> !init_done [*2];
  endproperty
  a_pd_flag: assert property (p_pd_flag) else $error("done flag set when down");
  property p_pd_ready;
    !chip_powerdown_n |-> !(s_axi_awready || s_axi_wready || s_axi_arready);
  endproperty
  a_pd_ready: assert property (p_pd_ready) else $error("bus ready when down");
  property p_mute;
    !init_done && !$fell(init_done) |-> input_gain_stage_a_mute && input_gain_stage_b_mute;
  endproperty
  a_mute: assert property (p_mute) else $error("gain stage live in init");
  property p_cal_zero;
    !init_done && $past(!init_done) |-> (capture_data_out_0 | capture_data_out_1) == 16'h0000;
  endproperty
  a_cal_zero: assert property (p_cal_zero) else $error("capture live in init");
  property p_cal_len;
    $rose(init_done) |-> st_r.cnt >= CNT_LO && st_r.cnt <= CNT_HI;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length off");
  property p_ctrl_ref;
    // A restart write sees the flag drop with its own response
    $rose(s_axi_bvalid) && !init_done && !$past(init_done) &&
      st_r.awa == codec_seq_pkg::ADDR_CTRL
      |-> s_axi_bresp == codec_seq_pkg::RESP_SLVERR;
  endproperty
  a_ctrl_ref: assert property (p_ctrl_ref) else $error("control write taken in init");
endmodule
bind codec_reset_init_sequencer codec_seq_checker u_codec_seq_checker (.*);

/* codec_seq_pkg.sv */
// What this block and its host must do
// R1 - MCLK runs at 256 or 384 fs
// R2 - 384 fs ratio scaled by two thirds
// R3 - Host keeps MCLK locked to frame clock
// R4 - Host supplies frame clock and bit clock
// R5 - Clocks run while converters active
// R6 - Host powers down before stopping clocks
// R7 - Host pulses power-down pin once
// R8 - Reset loads every register initial value
// R9 - Calibration lasts 4128 sample periods
// R10 - Capture outputs zero during calibration
// R11 - Playback path never waits for calibration
// R12 - Host avoids power register write during calibration
// R13 - Init-done flag low until done
// R14 - Input gain stages muted during init
// R15 - Power-down: capture zero, playback floats
// R16 - Full and read-only init phases
// R17 - Full and write-only access blocking
// R18 - Capture latency 17.0 sample periods
// R19 - Playback latency 14.8 sample periods
// R20 - Filter edges scale with sample rate
// R21 - Host slows peak-hold reads at low rate
// R22 - Power-down pin overrides block power bits
// R23 - Leaving capture power-down restarts calibration
// R24 - Init counted in frame clock periods
package codec_seq_pkg;
  localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
  localparam logic [31:0] ADDR_CAL_CNT  = 32'h0000_0008;
  localparam logic [31:0] ADDR_DATA_IN  = 32'h0000_000C;
  localparam logic [31:0] ADDR_CAP_OUT  = 32'h0000_0010;
  localparam logic [5:0]  PWR_RESET     = 6'h3F;
  localparam logic [12:0] CAL_PERIODS   = 13'h1020; // 4128
  localparam logic [4:0]  CAP_LAT       = 5'h11;    // 17 periods
  localparam logic [4:0]  PLAY_LAT      = 5'h0F;    // 14.8 rounded up
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  RATIO_CNT_256 = 2'h1;
  localparam logic [1:0]  RATIO_CNT_384 = 2'h2;
  localparam int          PWR_ADC_LO    = 2;

  typedef enum logic [3:0] {
    ST_PD   = 4'h1,
    ST_INIT1 = 4'h2,
    ST_INIT2 = 4'h4,
    ST_RUN  = 4'h8
  } phase_type;

  typedef struct packed {
    logic        cap_valid;
    logic [15:0] left;
    logic [15:0] right;
  } sample_type;
endpackage

/* host_clock_model.sv */
`timescale 1ns/1ps
// Host side: free-running frame and master clocks plus the pin
module host_clock_model
(
  input  wire logic aclk,
  input  wire logic pd_req_n,
  output logic      chip_powerdown_n = 1'b0,
  output logic      frame_select_clock = 1'b0,
  output logic      mclk_tick = 1'b0
);
  logic [1:0] ph_r = 2'h0;
  // Clocks never stop, so no power-down ordering hazard exists
  always_ff @(posedge aclk)
  begin
    ph_r <= ph_r + 2'h1;
    frame_select_clock <= ph_r[1];
    mclk_tick <= ph_r[0];
    chip_powerdown_n <= pd_req_n;
  end
endmodule

/* latency_line.sv */
`timescale 1ns/1ps
// Fixed sample-period delay line standing in for a filter's group delay
module latency_line
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [4:0]                depth,
  input  wire logic                      frame_tick,
  input  wire codec_seq_pkg::sample_type din,
  output codec_seq_pkg::sample_type      dout
);
  codec_seq_pkg::sample_type mem [0:31];
  typedef struct packed {
    logic [4:0]                wp;
    codec_seq_pkg::sample_type q;
  } lat_type;
  lat_type s_r, s_nxt;

  // Delay counted in frames so it scales with the sample rate
  always_comb
  begin
    s_nxt = s_r;
    if (frame_tick)
    begin
      s_nxt.wp = s_r.wp + 5'h1;
      s_nxt.q = mem[5'(s_r.wp - depth)]; // [R20]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (frame_tick)
      mem[s_r.wp] <= din;
    if (!aresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign dout = s_r.q;
endmodule

/* mclk_scaler.sv */
`timescale 1ns/1ps
// Turns master clock ticks into internal ticks at the 256 fs rate
module mclk_scaler
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ratio_384,
  input  wire logic mclk_tick,
  output logic      int_tick
);
  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } scl_type;
  scl_type s_r, s_nxt;

  // Pass two of every three ticks at 384 fs, all at 256 fs
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (mclk_tick)
    begin
      if (!ratio_384)
        s_nxt.tick = 1'b1; // [R1]
      else
      begin
        s_nxt.tick = (s_r.cnt != codec_seq_pkg::RATIO_CNT_384); // [R2]
        s_nxt.cnt = (s_r.cnt == codec_seq_pkg::RATIO_CNT_384) ? 2'h0
                    : s_r.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign int_tick = s_r.tick;
endmodule
